/* File: pkg/ussu_pkg.sv */
// ussu_pkg: register map, field positions, reset values and mode codes
// assumes: byte-wide register port, 20 MHz system clock
package ussu_pkg;
	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] USSU_OFF_CONTROL = 8'h0D;
	localparam logic [7:0] USSU_OFF_STATUS  = 8'h0E;
	localparam logic [7:0] USSU_OFF_DATA    = 8'h0F;
	localparam logic [7:0] USSU_OFF_CAPTURE = 8'h10;
	localparam logic [7:0] USSU_OFF_PINCTL  = 8'h11;
	// --------------------------------------------------------------
	// control fields
	// --------------------------------------------------------------
	localparam int CR_START_IE = 7;
	localparam int CR_WRAP_IE  = 6;
	localparam int CR_MODE_HI  = 5;
	localparam int CR_MODE_LO  = 4;
	localparam int CR_CLK_HI   = 3;
	localparam int CR_CLK_LO   = 2;
	localparam int CR_STROBE   = 1;
	localparam int CR_TOGGLE   = 0;
	// --------------------------------------------------------------
	// status fields
	// --------------------------------------------------------------
	localparam int SR_START    = 7;
	localparam int SR_WRAP     = 6;
	localparam int SR_STOP     = 5;
	localparam int SR_MISMATCH = 4;
	// pin control fields: data dir, clock dir, clock port level
	localparam int PC_DATA_DIR = 0;
	localparam int PC_CLK_DIR  = 1;
	localparam int PC_CLK_PORT = 2;
	// --------------------------------------------------------------
	// reset values and codes
	// --------------------------------------------------------------
	localparam logic [7:0] USSU_RST_BYTE = 8'h00;
	localparam logic [3:0] USSU_CNT_MAX  = 4'hF;
	localparam logic [1:0] MODE_OFF      = 2'h0;
	localparam logic [1:0] MODE_THREE    = 2'h1;
	localparam logic [1:0] MODE_TWO      = 2'h2;
	localparam logic [1:0] MODE_TWO_HOLD = 2'h3;
	localparam logic [1:0] CLK_SOFT      = 2'h0;
	localparam logic [1:0] CLK_TIMER     = 2'h1;
	localparam logic [1:0] CLK_EXT_POS   = 2'h2;
	localparam logic [1:0] CLK_EXT_NEG   = 2'h3;
endpackage : ussu_pkg

/* File: hw/ussu_sync.sv */
// ussu_sync: two-flop synchroniser for pin levels
// assumes: inputs asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module ussu_sync
	import ussu_pkg::*;
#(
	parameter int W = 2
)(
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} ussu_sync_t;
	ussu_sync_t s_q;
	ussu_sync_t s_d;
	// first stage feeds only the second
	always_comb
	begin
		s_d.meta = async_in;
		s_d.stab = s_q.meta;
	end
	// resets to the idle-high line level, so no false edge follows reset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			s_q <= '1;
		else
			s_q <= s_d;
	end
	assign sync_out = s_q.stab;
endmodule : ussu_sync
`default_nettype wire

/* File: hw/ussu_core.sv */
// ussu_core: universal serial shift unit, register port plus serial pins
// assumes: register strobes on sys_clk, pins asynchronous, partner clocks at most sys_clk/4
// Functional notes
// - start detector active only in two-wire modes
// - start detection is sampled, so it needs sys_clk running
// - two-wire slave holds SCL low until ready
// - external clock counts both edges
// - CPU write beats simultaneous shift
// - shift left on selected clock source
// - inputs still feed shifter with outputs off
// - data out via latch from bit 7
// - data out only when direction bit set
// - start flag from start or clock edge
// - start flag clears on written one, releases hold
// - start irq when flag, enable, global set
// - wrap flag on 15 to 0, clear rules
// - wrap irq when flag, enable, global set
// - stop flag set, write-one clear, no irq
// - mismatch reads bit 7 versus pin
// - counter readable and writable in status
// - toggle strobe clocks in external-strobe mode
// - pending flag interrupts as soon as enabled
// - counter preload F gives one-edge overflow
// - line mode decode of four codes
// - software strobe clocks shift and count
// - start forces SCL low until flag cleared, while the clock driver is enabled
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ussu_core
	import ussu_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// system side
	input  wire logic       global_irq_en,
	input  wire logic       timer_match,
	output logic            start_irq,
	output logic            wrap_irq,
	output logic            wake_any,
	output logic            wake_idle,
	// serial pins
	input  wire logic       serial_in_pin,
	input  wire logic       serial_clock_pin,
	output logic            data_out,
	output logic            data_oe,
	output logic            clock_out,
	output logic            clock_oe
);
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		logic       start_f;
		logic       wrap_f;
		logic       stop_f;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] capture;
		logic [2:0] pinctl;
		logic       latch;
		logic       sda_d1;
		logic       scl_d1;
		logic       start_hold;
		logic       clk_port;
		logic [7:0] rdata;
	} ussu_core_t;
	ussu_core_t r_q;
	ussu_core_t r_d;
	logic [1:0] pins_s;
	logic       sda_s;
	logic       scl_s;
	logic [1:0] mode;
	logic [1:0] csel;
	logic       two_wire;
	logic       wr_ctrl;
	logic       wr_stat;
	logic       wr_data;
	logic       rd_cap;
	logic       scl_rise;
	logic       scl_fall;
	logic       ext_edge;
	logic       sample_edge;
	logic       soft_clk;
	logic       tog_clk;
	logic       cnt_tick;
	logic       shift_tick;
	logic       start_seen;
	logic       stop_seen;
	logic       scl_low_req;
	logic       sda_low_req;
	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	// sampling at sys_clk needs partner clock <= sys_clk/4 to see every edge
	ussu_sync #(.W(2)) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({serial_in_pin, serial_clock_pin}),
		.sync_out (pins_s)
	);
	assign sda_s = pins_s[1];
	assign scl_s = pins_s[0];
	// --------------------------------------------------------------
	// decode and clock selection
	// --------------------------------------------------------------
	always_comb
	begin
		mode     = r_q.ctrl[CR_MODE_HI:CR_MODE_LO];
		csel     = r_q.ctrl[CR_CLK_HI:CR_CLK_LO];
		two_wire = (mode == MODE_TWO) || (mode == MODE_TWO_HOLD);
		wr_ctrl  = 1'b0;
		wr_stat  = 1'b0;
		wr_data  = 1'b0;
		rd_cap   = 1'b0;
		if (reg_wr && reg_addr == USSU_OFF_CONTROL)
			wr_ctrl = 1'b1;
		else if (reg_wr && reg_addr == USSU_OFF_STATUS)
			wr_stat = 1'b1;
		else if (reg_wr && reg_addr == USSU_OFF_DATA)
			wr_data = 1'b1;
		if (reg_rd && reg_addr == USSU_OFF_CAPTURE)
			rd_cap = 1'b1;
		scl_rise = scl_s && !r_q.scl_d1;
		scl_fall = !scl_s && r_q.scl_d1;
		ext_edge = scl_rise || scl_fall;
		// shift samples on the chosen edge, counter takes both unless the strobe bit is set
		sample_edge = (csel == CLK_EXT_NEG) ? scl_fall : scl_rise;
		// software strobes decode the written word, but clock only while the stored select is already software
		soft_clk = wr_ctrl && reg_wdata[CR_STROBE] && (reg_wdata[CR_CLK_HI:CR_CLK_LO] == CLK_SOFT);
		tog_clk  = wr_ctrl && reg_wdata[CR_TOGGLE] && reg_wdata[CR_CLK_HI] && reg_wdata[CR_STROBE];
		cnt_tick   = 1'b0;
		shift_tick = 1'b0;
		case (csel)
			CLK_TIMER:
			begin
				cnt_tick   = timer_match;
				shift_tick = timer_match;
			end
			CLK_EXT_POS, CLK_EXT_NEG:
			begin
				shift_tick = sample_edge;
				// strobe set: only toggle writes count; else both pin edges count
				if (r_q.ctrl[CR_STROBE])
					cnt_tick = tog_clk;
				else
					cnt_tick = ext_edge;
			end
			default:
			begin
				// a toggle write that selects the external strobe counts at once
				cnt_tick   = soft_clk || tog_clk;
				shift_tick = soft_clk;
			end
		endcase
		// start: data falls while clock high; stop: data rises while clock high
		start_seen  = two_wire && scl_s && r_q.sda_d1 && !sda_s;
		stop_seen   = two_wire && scl_s && !r_q.sda_d1 && sda_s;
		scl_low_req = r_q.start_hold || (mode == MODE_TWO_HOLD && r_q.wrap_f) || !r_q.clk_port;
		sda_low_req = !r_q.latch;
	end
	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb
	begin
		r_d        = r_q;
		r_d.sda_d1 = sda_s;
		r_d.scl_d1 = scl_s;
		r_d.rdata  = USSU_RST_BYTE;
		// control: toggle bit is never stored; strobe bit is stored but reads back as zero
		if (wr_ctrl)
		begin
			r_d.ctrl = reg_wdata;
			r_d.ctrl[CR_TOGGLE] = 1'b0;
			if (reg_wdata[CR_TOGGLE])
				r_d.clk_port = !r_q.clk_port;
		end
		if (reg_wr && reg_addr == USSU_OFF_PINCTL)
			r_d.pinctl = reg_wdata[2:0];
		// counter: CPU write wins over a tick in the same cycle
		if (cnt_tick)
			r_d.cnt = r_q.cnt + 4'h1;
		if (wr_stat)
			r_d.cnt = reg_wdata[3:0];
		// shifter: CPU write wins, no shift that cycle
		if (wr_data)
			r_d.shreg = reg_wdata;
		else if (shift_tick)
			r_d.shreg = {r_q.shreg[6:0], sda_s};
		// output latch: open on internal clock; on external it shuts at the sampling edge
		if (!csel[1] || scl_s == (csel == CLK_EXT_NEG))
			r_d.latch = r_d.shreg[7];
		// flags: clear by write-one, a set in the same cycle wins, except a wrap during any status write
		if (wr_stat && reg_wdata[SR_START])
		begin
			r_d.start_f    = 1'b0;
			r_d.start_hold = 1'b0;
		end
		if ((wr_stat && reg_wdata[SR_WRAP]) || rd_cap)
			r_d.wrap_f = 1'b0;
		if (wr_stat && reg_wdata[SR_STOP])
			r_d.stop_f = 1'b0;
		if (start_seen)
		begin
			r_d.start_f = 1'b1;
			// hold engages only while the clock driver is enabled
			if (r_q.pinctl[PC_CLK_DIR])
				r_d.start_hold = 1'b1;
		end
		if (!two_wire && csel[1] && !r_q.ctrl[CR_STROBE] && ext_edge)
			r_d.start_f = 1'b1;
		if (cnt_tick && r_q.cnt == USSU_CNT_MAX && !wr_stat)
		begin
			r_d.wrap_f  = 1'b1;
			r_d.capture = r_d.shreg;
		end
		if (stop_seen)
			r_d.stop_f = 1'b1;
		// read data appears the cycle after the strobe, zero otherwise
		if (reg_rd)
		begin
			if (reg_addr == USSU_OFF_CONTROL)
				r_d.rdata = {r_q.ctrl[7:2], 2'b00};
			else if (reg_addr == USSU_OFF_STATUS)
				r_d.rdata = {r_q.start_f, r_q.wrap_f, r_q.stop_f, r_q.shreg[7] != sda_s, r_q.cnt};
			else if (reg_addr == USSU_OFF_DATA)
				r_d.rdata = r_q.shreg;
			else if (reg_addr == USSU_OFF_CAPTURE)
				r_d.rdata = r_q.capture;
			else if (reg_addr == USSU_OFF_PINCTL)
				r_d.rdata = {5'h00, r_q.pinctl};
			else
				r_d.rdata = USSU_RST_BYTE;
		end
	end
	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			r_q          <= '0;
			r_q.clk_port <= 1'b1;
			r_q.sda_d1   <= 1'b1;
			r_q.scl_d1   <= 1'b1;
		end
		else
			r_q <= r_d;
	end
	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	// level requests, live as soon as enables change (pending fires at once)
	assign start_irq = r_q.start_f && r_q.ctrl[CR_START_IE] && global_irq_en;
	assign wrap_irq  = r_q.wrap_f && r_q.ctrl[CR_WRAP_IE] && global_irq_en;
	// wake requests: start from any sleep, wrap only from idle
	// limitation: start detection is sampled, so sys_clk must run; a clockless
	// wake path would sit in the pad ring outside this core
	assign wake_any  = start_irq;
	assign wake_idle = wrap_irq;
	assign reg_rdata = r_q.rdata;
	// pin drive per line mode; open drain only ever drives low
	always_comb
	begin
		data_out  = 1'b0;
		data_oe   = 1'b0;
		clock_out = 1'b0;
		clock_oe  = 1'b0;
		case (mode)
			MODE_THREE:
			begin
				data_out  = r_q.latch;
				data_oe   = r_q.pinctl[PC_DATA_DIR];
				clock_out = r_q.clk_port;
				clock_oe  = r_q.pinctl[PC_CLK_DIR];
			end
			MODE_TWO, MODE_TWO_HOLD:
			begin
				data_oe  = r_q.pinctl[PC_DATA_DIR] && sda_low_req;
				clock_oe = r_q.pinctl[PC_CLK_DIR] && scl_low_req;
			end
			default:
			begin
				data_oe  = 1'b0;
				clock_oe = 1'b0;
			end
		endcase
	end
endmodule : ussu_core
`default_nettype wire

/* File: bench/ussu_core_asserts.sv */
// ussu_core_asserts: port-level checks for the serial shift unit
// assumes: bound to ussu_core, strobes and flags on sys_clk
`timescale 1ns/1ps
`default_nettype none
module ussu_core_asserts
	import ussu_pkg::*;
(
	// clock, reset, register port
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// system side and pins
	input wire logic       global_irq_en,
	input wire logic       timer_match,
	input wire logic       start_irq,
	input wire logic       wrap_irq,
	input wire logic       wake_any,
	input wire logic       wake_idle,
	input wire logic       serial_in_pin,
	input wire logic       serial_clock_pin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// --------------------------------------------------------------
	// pin calm time: an edge lands three cycles late and may set a flag
	// --------------------------------------------------------------
	logic [1:0] pin_q;
	logic [2:0] quiet_q;
	wire logic  calm;
	assign calm = quiet_q > 3'h4;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_q   <= 2'h3;
			quiet_q <= 3'h0;
		end
		else
		begin
			pin_q   <= {serial_in_pin, serial_clock_pin};
			quiet_q <= (pin_q != {serial_in_pin, serial_clock_pin}) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
		end
	end
	// --------------------------------------------------------------
	// properties
	// --------------------------------------------------------------
	a_wake_any_same: assert property (wake_any == start_irq)
		else $error("wake_any differs from start_irq");
	a_wake_idle_same: assert property (wake_idle == wrap_irq)
		else $error("wake_idle differs from wrap_irq");
	a_irq_global_gate: assert property (!global_irq_en |-> !start_irq && !wrap_irq)
		else $error("interrupt without global enable");
	a_strobe_reads_zero: assert property ($past(reg_rd) && $past(reg_addr) == USSU_OFF_CONTROL |-> reg_rdata[1:0] == 2'h0)
		else $error("strobe bits read back nonzero");
	a_start_ie_drop: assert property (reg_wr && reg_addr == USSU_OFF_CONTROL && !reg_wdata[CR_START_IE] |=> !start_irq)
		else $error("start irq with enable cleared");
	a_start_flag_clear: assert property (reg_wr && reg_addr == USSU_OFF_STATUS && reg_wdata[SR_START] && calm |=> !start_irq)
		else $error("start flag not cleared by one");
	a_wrap_flag_clear: assert property (reg_wr && reg_addr == USSU_OFF_STATUS && reg_wdata[SR_WRAP] && calm && !timer_match |=> !wrap_irq)
		else $error("wrap flag not cleared by one");
	a_capture_read_clear: assert property (reg_rd && reg_addr == USSU_OFF_CAPTURE && calm && !timer_match |=> !wrap_irq)
		else $error("capture read left wrap flag");
endmodule : ussu_core_asserts
`default_nettype wire

/* File: bench/ussu_partner.sv */
// ussu_partner: serial partner, clocks frames in and out of the unit
// assumes: bench resolves wire levels; clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module ussu_partner (
	// frame request and wire levels
	input  wire logic       go,
	input  wire logic       with_start,
	input  wire logic [3:0] n_bits,
	input  wire logic [7:0] tx_byte,
	input  wire logic       scl_wire,
	input  wire logic       dev_data,
	// drives and result
	output var  logic       sck,
	output var  logic       sdo,
	output var  logic       busy,
	output var  logic [7:0] rx_byte
);
	// idle: clock high, data released to its pull-up
	initial
	begin
		sck = 1'b1;
		sdo = 1'b1;
		busy = 1'b0;
		rx_byte = 8'h00;
	end
	// one frame, 200 ns half period: an eighth of sys_clk, half of the quarter limit
	always @(posedge go)
	begin
		busy = 1'b1;
		if (with_start)
		begin
			sdo = 1'b0;
			#200;
			sck = 1'b0;
			#200;
			sck = 1'b1;
		end
		for (int i = 0; i < int'(n_bits); i++)
		begin
			sck = 1'b0;
			sdo = tx_byte[7-i];
			#200;
			sck = 1'b1;
			rx_byte = {rx_byte[6:0], dev_data};
			#200;
		end
		// a held clock line stretches the frame, bounded at 20 us
		for (int n = 0; n < 400 && !scl_wire; n++)
			#50;
		#200;
		sdo = 1'b1;
		#200;
		busy = 1'b0;
	end
endmodule : ussu_partner
`default_nettype wire

/* File: bench/testbench.sv */
// testbench: register table, interrupts, three- and two-wire frames
// assumes: ussu_core, ussu_partner and the checker compiled before
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ussu_pkg::*;
;
	typedef struct { logic [7:0] wa, wd, ra, ex; } ussu_row_t;
	logic       sys_clk = 1'b0, rst, reg_wr, reg_rd, global_irq_en, timer_match, tw;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, p_tx, p_rx;
	logic       start_irq, wrap_irq, wake_any, wake_idle, data_out, data_oe, clock_out, clock_oe;
	logic       p_go, p_start, p_sck, p_sdo, p_busy;
	logic [3:0] p_n;
	int         error_cnt = 0, comparisons = 0;
	wire logic  serial_clock_pin, serial_in_pin;
	// wire levels: the unit only ever pulls low in two-wire mode
	assign serial_clock_pin = clock_oe ? clock_out : p_sck;
	assign serial_in_pin    = (tw && data_oe) ? data_out : p_sdo;
	ussu_core dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en), .timer_match(timer_match),
		.start_irq(start_irq), .wrap_irq(wrap_irq), .wake_any(wake_any), .wake_idle(wake_idle),
		.serial_in_pin(serial_in_pin), .serial_clock_pin(serial_clock_pin), .data_out(data_out),
		.data_oe(data_oe), .clock_out(clock_out), .clock_oe(clock_oe));
	ussu_partner part_u (.go(p_go), .with_start(p_start), .n_bits(p_n), .tx_byte(p_tx), .scl_wire(serial_clock_pin),
		.dev_data(data_oe ? data_out : 1'b1), .sck(p_sck), .sdo(p_sdo), .busy(p_busy), .rx_byte(p_rx));
	always #25 sys_clk = ~sys_clk;
	// rows: write, then read back; status bit 4 is data bit 7 inverted, a mismatch against the idle-high pin
	ussu_row_t rows [12] = '{'{8'h0D, 8'hFC, 8'h0D, 8'hFC}, '{8'h0D, 8'h00, 8'h0D, 8'h00},
		'{8'h0F, 8'hA5, 8'h0F, 8'hA5}, '{8'h0E, 8'h05, 8'h0E, 8'h05},
		'{8'h0D, 8'h02, 8'h0F, 8'h4B}, '{8'h0D, 8'h00, 8'h0E, 8'h16},
		'{8'h20, 8'hFF, 8'h20, 8'h00}, '{8'h0E, 8'h0F, 8'h0E, 8'h1F},
		'{8'h0D, 8'h02, 8'h0E, 8'h40}, '{8'h20, 8'h00, 8'h10, 8'h97},
		'{8'h20, 8'h00, 8'h0E, 8'h00}, '{8'h0D, 8'h0B, 8'h0E, 8'h01}};
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		comparisons++;
		if (got !== ex)
		begin
			$display("BAD %s expected %h seen %h", nm, ex, got);
			error_cnt++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", ex, reg_rdata & m);
	endtask : rchk
	// bounded wait on a level; running out ends the run
	task automatic wait_lvl(ref logic s, input logic v);
		for (int n = 0; n < 2000 && s !== v; n++)
			@(posedge sys_clk);
		#1;
		chk("wait", {7'h0, v}, {7'h0, s});
		if (s !== v)
			summarize();
	endtask : wait_lvl
	task automatic frame(input logic st, input logic [3:0] n, input logic [7:0] tx);
		p_start <= st;
		p_n     <= n;
		p_tx    <= tx;
		p_go    <= 1'b1;
		@(posedge sys_clk);
		p_go <= 1'b0;
	endtask : frame
	initial
	begin
		{rst, global_irq_en, tw} = 3'b111;
		{reg_wr, reg_rd, timer_match, p_go, p_start} = 5'h0;
		{reg_addr, reg_wdata, p_tx, p_n} = 28'h0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		tw  <= 1'b0;
		@(posedge sys_clk);
		foreach (rows[i])
		begin
			wr(rows[i].wa, rows[i].wd);
			rchk(rows[i].ra, rows[i].ex, 8'hFF);
		end
		$display("register rows done");
		// timer clock, preload F, data write beating the shift
		wr(USSU_OFF_CONTROL, 8'h05);
		wr(USSU_OFF_STATUS, 8'h4F);
		timer_match <= 1'b1;
		wr(USSU_OFF_DATA, 8'h81);
		timer_match <= 1'b0;
		rchk(USSU_OFF_STATUS, 8'h40, 8'hFF);
		rchk(USSU_OFF_DATA, 8'h81, 8'hFF);
		chk("wrap_irq", 8'h0, {7'h0, wrap_irq});
		wr(USSU_OFF_CONTROL, 8'h44);
		chk("wake_idle", 8'h1, {7'h0, wake_idle});
		global_irq_en <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("wrap_irq", 8'h0, {7'h0, wrap_irq});
		global_irq_en <= 1'b1;
		wr(USSU_OFF_STATUS, 8'h40);
		chk("wrap_irq", 8'h0, {7'h0, wrap_irq});
		$display("interrupt test done");
		// three-wire byte exchange on the external clock, both edges counted
		wr(USSU_OFF_PINCTL, 8'h01);
		wr(USSU_OFF_CONTROL, 8'h18);
		wr(USSU_OFF_DATA, 8'h3C);
		wr(USSU_OFF_STATUS, 8'hE0);
		frame(1'b0, 4'h8, 8'hC3);
		wait_lvl(p_busy, 1'b0);
		rchk(USSU_OFF_STATUS, 8'hC0, 8'hFF);
		rchk(USSU_OFF_DATA, 8'hC3, 8'hFF);
		chk("rx", 8'h3C, p_rx);
		chk("clock_out", 8'h1, {7'h0, clock_out});
		$display("three-wire test done");
		// two-wire start: clock held low until the flag is cleared, then a stop
		wr(USSU_OFF_STATUS, 8'hE0);
		wr(USSU_OFF_PINCTL, 8'h02);
		tw <= 1'b1;
		wr(USSU_OFF_CONTROL, 8'hA8);
		frame(1'b1, 4'h0, 8'h00);
		wait_lvl(clock_oe, 1'b1);
		chk("wake_any", 8'h1, {7'h0, wake_any});
		wr(USSU_OFF_STATUS, 8'h80);
		chk("clock_oe", 8'h0, {7'h0, clock_oe});
		wait_lvl(p_busy, 1'b0);
		rchk(USSU_OFF_STATUS, 8'h20, 8'hE0);
		chk("start_irq", 8'h0, {7'h0, start_irq});
		$display("two-wire test done");
		// hold mode: a wrap pulls the clock low until the wrap flag clears
		wr(USSU_OFF_CONTROL, 8'h30);
		wr(USSU_OFF_STATUS, 8'h0F);
		wr(USSU_OFF_CONTROL, 8'h32);
		chk("clock_oe", 8'h1, {7'h0, clock_oe});
		chk("clock_out", 8'h0, {7'h0, clock_out});
		wr(USSU_OFF_STATUS, 8'h40);
		chk("clock_oe", 8'h0, {7'h0, clock_oe});
		$display("hold test done");
		// second reset in mid-run; status bit 4 is live and masked
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		tw  <= 1'b0;
		@(posedge sys_clk);
		rchk(USSU_OFF_CONTROL, 8'h00, 8'hFF);
		rchk(USSU_OFF_STATUS, 8'h00, 8'hEF);
		$display("reset test done");
		summarize();
	end
endmodule : testbench
bind ussu_core ussu_core_asserts chk_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
	.timer_match(timer_match), .start_irq(start_irq), .wrap_irq(wrap_irq), .wake_any(wake_any),
	.wake_idle(wake_idle), .serial_in_pin(serial_in_pin), .serial_clock_pin(serial_clock_pin));
`default_nettype wire
